// ### rtl/ufr_uart.sv
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module ufr_uart
	import ufr_pkg::*;
#(
	parameter int RX_DEPTH = 2
)(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        global_irq_enable,
	input  wire logic        tx_complete_irq_ack,
	output logic             irq_tx_empty,
	output logic             irq_tx_complete,
	output logic             irq_rx_complete,
	input  wire logic        serial_in_pin,
	input  wire logic        sync_transfer_clock_pin,
	output logic             serial_out_pin,
	output logic             serial_out_pin_oe,
	output logic             serial_in_claim
);

	localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CNT_W = $clog2(RX_DEPTH + 1);

	if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("RX_DEPTH must be a power of two of at least two");
	end

	logic [31:0]     avs_readdata_reg, rd_mux;
	logic            avs_waitrequest_reg;
	logic            wr_acc, rd_acc, sel_data, sel_status, sel_ctrl, sel_format, sel_baud;
	logic            wr_data, wr_status, rd_data;
	logic [7:0]      ctrl_reg, format_reg;
	logic [15:0]     baud_reg;
	ufr_frame_cfg_t  cfg;
	logic [3:0]      last_idx;
	logic [8:0]      data_mask;
	logic [2:0]      rxd_sync_reg, xck_sync_reg;
	logic            rxd_f_reg, rxd_prev_reg, xck_f_reg, xck_prev_reg, xck_rise, xck_fall;
	ufr_tx_state_t   tx_state_reg, tx_state_next;
	logic [3:0]      tx_bit_reg;
	logic [15:0]     tx_cnt_reg;
	logic [8:0]      txbuf_reg, tx_shift_reg;
	logic            txbuf_valid_reg, tx_en_eff_reg, tx_en_eff_next, txc_reg, txc_next;
	logic            tx_tick, tx_last, tx_end, tx_load, tx_par, tx_line;
	logic            serial_out_reg, serial_out_oe_reg, serial_in_claim_reg;
	logic            irq_tx_empty_reg, irq_tx_complete_reg, irq_rx_complete_reg;
	logic            rx_on, rx_tick, rx_start, rx_last, rx_done, rx_ovr, rx_pe;
	ufr_rx_state_t   rx_state_reg, rx_state_next;
	logic [3:0]      rx_bit_reg;
	logic [15:0]     rx_cnt_reg, rx_cnt_next;
	logic [8:0]      rx_data_reg;
	logic            rx_par_reg;
	ufr_rx_entry_t   hold_reg, hold_next, head;
	logic            hold_valid_reg, hold_push, fifo_pop, rx_complete;
	ufr_rx_entry_t   fifo_mem [RX_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;

	// Bus decode. A request is answered one cycle after it appears, then takes effect.
	assign wr_acc     = avs_write & ~avs_waitrequest_reg;
	assign rd_acc     = avs_read & ~avs_waitrequest_reg;
	assign sel_data   = avs_address == UFR_OFF_DATA;
	assign sel_status = avs_address == UFR_OFF_STATUS;
	assign sel_ctrl   = avs_address == UFR_OFF_CTRL;
	assign sel_format = avs_address == UFR_OFF_FORMAT;
	assign sel_baud   = avs_address == UFR_OFF_BAUD;
	assign wr_data    = wr_acc & sel_data & avs_byteenable[0];
	assign wr_status  = wr_acc & sel_status & avs_byteenable[0];
	assign rd_data    = rd_acc & sel_data;

	assign cfg = {format_reg[UFR_FM_SYNC], format_reg[UFR_FM_PAR_EN], format_reg[UFR_FM_PAR_ODD],
		format_reg[UFR_FM_STOP2], ctrl_reg[UFR_CT_SIZE2], format_reg[UFR_FM_SIZE_LO+:2]};
	// Reserved size codes 4 to 6 behave as eight data bits.
	assign last_idx  = (cfg.char_size_field == UFR_SIZE_NINE) ? 4'h8 :
		(cfg.char_size_field[2] ? 4'h7 : {2'h0, cfg.char_size_field[1:0]} + 4'h4);
	assign data_mask = 9'h1FF >> (4'h8 - last_idx);

	assign head        = fifo_mem[rd_ptr_reg];
	assign rx_complete = count_reg != '0;
	assign rd_mux = sel_data ? {24'h0, head.data[7:0]} :
		sel_status ? {24'h0, rx_complete, txc_reg, ~txbuf_valid_reg,
			head.fe & rx_complete, head.dor & rx_complete, head.pe & rx_complete, 2'h0} :
		sel_ctrl ? {24'h0, ctrl_reg[7:2], head.data[8], ctrl_reg[0]} :
		sel_format ? {24'h0, 1'h0, format_reg[6:1], 1'h0} :
		sel_baud ? {16'h0, baud_reg} : 32'h0;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			avs_waitrequest_reg <= 1'h1;
			avs_readdata_reg    <= 32'h0;
		end
		else
		begin
			avs_waitrequest_reg <= ~((avs_read | avs_write) & avs_waitrequest_reg);
			if (avs_read & avs_waitrequest_reg)
				avs_readdata_reg <= rd_mux;
		end
	end

	// Status writes only reach the transmit-complete bit; the error flags live in the FIFO.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl_reg   <= UFR_CTRL_RST;
			format_reg <= UFR_FORMAT_RST;
			baud_reg   <= UFR_BAUD_RST;
		end
		else
		begin
			if (wr_acc & sel_ctrl & avs_byteenable[0])
				ctrl_reg <= avs_writedata[7:0];
			if (wr_acc & sel_format & avs_byteenable[0])
				format_reg <= avs_writedata[7:0];
			if (wr_acc & sel_baud & avs_byteenable[0])
				baud_reg[7:0] <= avs_writedata[7:0];
			if (wr_acc & sel_baud & avs_byteenable[1])
				baud_reg[15:8] <= avs_writedata[15:8];
		end
	end

	// Pin inputs: three stages, a level counts once the second and third agree.
	assign xck_rise = xck_f_reg & ~xck_prev_reg;
	assign xck_fall = ~xck_f_reg & xck_prev_reg;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rxd_sync_reg <= 3'h7;
			xck_sync_reg <= 3'h0;
			rxd_f_reg    <= 1'h1;
			rxd_prev_reg <= 1'h1;
			xck_f_reg    <= 1'h0;
			xck_prev_reg <= 1'h0;
		end
		else
		begin
			rxd_sync_reg <= {rxd_sync_reg[1:0], serial_in_pin};
			xck_sync_reg <= {xck_sync_reg[1:0], sync_transfer_clock_pin};
			if (rxd_sync_reg[1] == rxd_sync_reg[2])
				rxd_f_reg <= rxd_sync_reg[2];
			if (xck_sync_reg[1] == xck_sync_reg[2])
				xck_f_reg <= xck_sync_reg[2];
			rxd_prev_reg <= rxd_f_reg;
			xck_prev_reg <= xck_f_reg;
		end
	end

	// Transmitter. In sync mode bits change on the falling edge of the transfer clock.
	assign tx_tick = cfg.sync_mode ? xck_fall : (tx_cnt_reg == 16'h0);
	assign tx_last = tx_bit_reg == last_idx;
	assign tx_end  = tx_tick & ((tx_state_reg == TX_STOP1 & ~cfg.stop_bits_select) |
		tx_state_reg == TX_STOP2);
	assign tx_load = txbuf_valid_reg & tx_en_eff_reg & (tx_state_reg == TX_IDLE | tx_end);
	assign tx_par  = ^(tx_shift_reg & data_mask) ^ cfg.parity_type_bit;
	assign tx_line = (tx_state_reg == TX_START) ? 1'h0 :
		(tx_state_reg == TX_DATA) ? tx_shift_reg[tx_bit_reg] :
		(tx_state_reg == TX_PARITY) ? tx_par : 1'h1;
	assign txc_next = (tx_end & ~txbuf_valid_reg) |
		(txc_reg & ~(tx_complete_irq_ack | (wr_status & avs_writedata[UFR_ST_TXC])));
	// The enable is held until nothing is left to send, so a late disable never truncates.
	assign tx_en_eff_next = ctrl_reg[UFR_CT_TRANSMITTER_ENABLE] |
		(tx_en_eff_reg & (tx_state_reg != TX_IDLE | txbuf_valid_reg));

	always_comb
	begin
		tx_state_next = tx_state_reg;
		unique case (tx_state_reg)
			TX_IDLE:   tx_state_next = TX_IDLE;
			TX_START:  if (tx_tick) tx_state_next = TX_DATA;
			TX_DATA:   if (tx_tick & tx_last)
				tx_state_next = cfg.parity_enable_bit ? TX_PARITY : TX_STOP1;
			TX_PARITY: if (tx_tick) tx_state_next = TX_STOP1;
			TX_STOP1:  if (tx_tick) tx_state_next = cfg.stop_bits_select ? TX_STOP2 : TX_IDLE;
			TX_STOP2:  if (tx_tick) tx_state_next = TX_IDLE;
		endcase
		if (tx_load)
			tx_state_next = TX_START;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tx_state_reg      <= TX_IDLE;
			tx_bit_reg        <= 4'h0;
			tx_cnt_reg        <= 16'h0;
			tx_shift_reg      <= 9'h0;
			txbuf_reg         <= 9'h0;
			txbuf_valid_reg   <= 1'h0;
			tx_en_eff_reg     <= 1'h0;
			txc_reg           <= 1'h0;
			serial_out_reg    <= 1'h1;
			serial_out_oe_reg <= 1'h0;
		end
		else
		begin
			tx_state_reg <= tx_state_next;
			tx_cnt_reg   <= (tx_load | tx_cnt_reg == 16'h0) ? baud_reg : tx_cnt_reg - 16'h1;
			tx_bit_reg   <= tx_load ? 4'h0 :
				(tx_state_reg == TX_DATA & tx_tick) ? tx_bit_reg + 4'h1 : tx_bit_reg;
			if (tx_load)
				tx_shift_reg <= txbuf_reg;
			if (wr_data)
				txbuf_reg <= {ctrl_reg[UFR_CT_TX_NINTH_BIT], avs_writedata[7:0]};
			txbuf_valid_reg   <= wr_data | (txbuf_valid_reg & ~tx_load);
			tx_en_eff_reg     <= tx_en_eff_next;
			txc_reg           <= txc_next;
			serial_out_reg    <= tx_en_eff_reg ? tx_line : 1'h1;
			serial_out_oe_reg <= tx_en_eff_reg;
		end
	end

	// Receiver. Sync mode samples on the rising edge of the transfer clock.
	assign rx_on    = ctrl_reg[UFR_CT_RXEN];
	assign rx_tick  = cfg.sync_mode ? xck_rise : (rx_cnt_reg == 16'h0);
	assign rx_start = rx_on & rx_state_reg == RX_IDLE &
		(cfg.sync_mode ? (xck_rise & ~rxd_f_reg) : (rxd_prev_reg & ~rxd_f_reg));
	assign rx_last  = rx_bit_reg == last_idx;
	assign rx_done  = rx_on & rx_state_reg == RX_STOP & rx_tick;
	assign rx_pe    = cfg.parity_enable_bit &
		((^(rx_data_reg & data_mask) ^ cfg.parity_type_bit) != rx_par_reg);
	assign rx_ovr   = rx_start & hold_valid_reg & count_reg == CNT_W'(RX_DEPTH);
	assign rx_cnt_next = rx_start ? {1'h0, baud_reg[15:1]} :
		(rx_cnt_reg == 16'h0) ? baud_reg : rx_cnt_reg - 16'h1;
	assign hold_push = hold_valid_reg & count_reg != CNT_W'(RX_DEPTH);
	assign fifo_pop  = rd_data & rx_complete;

	always_comb
	begin
		rx_state_next = rx_state_reg;
		unique case (rx_state_reg)
			RX_IDLE:   if (rx_start) rx_state_next = cfg.sync_mode ? RX_DATA : RX_START;
			RX_START:  if (rx_tick) rx_state_next = rxd_f_reg ? RX_IDLE : RX_DATA;
			RX_DATA:   if (rx_tick & rx_last)
				rx_state_next = cfg.parity_enable_bit ? RX_PARITY : RX_STOP;
			RX_PARITY: if (rx_tick) rx_state_next = RX_STOP;
			RX_STOP:   if (rx_tick) rx_state_next = RX_IDLE;
		endcase
		if (!rx_on)
			rx_state_next = RX_IDLE;
	end

	// A frame waiting in the holder is overwritten if the buffer never drains; dor marks it.
	always_comb
	begin
		hold_next = hold_reg;
		if (rx_ovr)
			hold_next.dor = 1'h1;
		if (rx_done)
		begin
			hold_next.data = rx_data_reg & data_mask;
			hold_next.fe   = ~rxd_f_reg;
			hold_next.pe   = rx_pe;
			hold_next.dor  = hold_valid_reg & ~hold_push;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rx_state_reg   <= RX_IDLE;
			rx_bit_reg     <= 4'h0;
			rx_cnt_reg     <= 16'h0;
			rx_data_reg    <= 9'h0;
			rx_par_reg     <= 1'h0;
			hold_reg       <= '0;
			hold_valid_reg <= 1'h0;
		end
		else
		begin
			rx_state_reg <= rx_state_next;
			rx_cnt_reg   <= rx_cnt_next;
			hold_reg     <= hold_next;
			hold_valid_reg <= rx_on & (rx_done | (hold_valid_reg & ~hold_push));
			if (rx_start)
			begin
				rx_data_reg <= 9'h0;
				rx_bit_reg  <= 4'h0;
			end
			else if (rx_state_reg == RX_DATA & rx_tick)
			begin
				rx_data_reg[rx_bit_reg] <= rxd_f_reg;
				rx_bit_reg              <= rx_bit_reg + 4'h1;
			end
			if (rx_state_reg == RX_PARITY & rx_tick)
				rx_par_reg <= rxd_f_reg;
		end
	end

	// Receive FIFO; disabling the receiver empties it at once.
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !rx_on)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (hold_push)
				wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
			if (fifo_pop)
				rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
			count_reg <= count_reg + CNT_W'(hold_push) - CNT_W'(fifo_pop);
		end
	end

	for (genvar i = 0; i < RX_DEPTH; i++)
	begin : g_fifo
		always_ff @(posedge mclk)
		begin
			if (!rst_n)
				fifo_mem[i] <= '0;
			else if (hold_push & wr_ptr_reg == PTR_W'(i))
				fifo_mem[i] <= hold_reg;
		end
	end

	// Error flags are not routed here: they never request an interrupt.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			irq_tx_empty_reg    <= 1'h0;
			irq_tx_complete_reg <= 1'h0;
			irq_rx_complete_reg <= 1'h0;
			serial_in_claim_reg <= 1'h0;
		end
		else
		begin
			irq_tx_empty_reg    <= global_irq_enable & ctrl_reg[UFR_CT_UDRIE] & ~txbuf_valid_reg;
			irq_tx_complete_reg <= global_irq_enable & ctrl_reg[UFR_CT_TXCIE] & txc_reg;
			irq_rx_complete_reg <= global_irq_enable & ctrl_reg[UFR_CT_RXCIE] & rx_complete;
			serial_in_claim_reg <= rx_on;
		end
	end

	assign avs_readdata      = avs_readdata_reg;
	assign avs_waitrequest   = avs_waitrequest_reg;
	assign irq_tx_empty      = irq_tx_empty_reg;
	assign irq_tx_complete   = irq_tx_complete_reg;
	assign irq_rx_complete   = irq_rx_complete_reg;
	assign serial_out_pin    = serial_out_reg;
	assign serial_out_pin_oe = serial_out_oe_reg;
	assign serial_in_claim   = serial_in_claim_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	tx_buffer_move_a: assert property ((tx_load & ~wr_data & tx_state_reg == TX_IDLE) |=>
		(~txbuf_valid_reg & tx_state_reg == TX_START)) else $error("buffer not moved to shifter");
	tx_empty_irq_a: assert property ((global_irq_enable & ctrl_reg[UFR_CT_UDRIE] &
		~txbuf_valid_reg) [*2] |-> irq_tx_empty) else $error("empty interrupt missing");
	data_write_clear_a: assert property (wr_data |=> txbuf_valid_reg
		##1 irq_tx_empty == 1'h0) else $error("data write did not clear empty flag");
	tx_complete_set_a: assert property ((tx_end & ~txbuf_valid_reg) |=> txc_reg ##0
		(tx_state_reg == TX_IDLE)) else $error("complete flag not set");
	tx_complete_clr_a: assert property ((tx_complete_irq_ack & ~tx_end) |=> ~txc_reg)
		else $error("complete flag not cleared by service");
	tx_parity_slot_a: assert property ((tx_state_reg == TX_DATA & tx_tick & tx_last &
		cfg.parity_enable_bit & ~tx_load) |=> tx_state_reg == TX_PARITY) else $error("no parity");
	tx_disable_hold_a: assert property ((tx_state_reg != TX_IDLE & tx_en_eff_reg) |=>
		##1 serial_out_pin_oe) else $error("pin released while sending");
	rx_flush_a: assert property ($fell(rx_on) |=> (~rx_complete & rx_state_reg == RX_IDLE)
		##1 ~irq_rx_complete) else $error("receiver disable did not flush");
	status_write_keep_a: assert property ((wr_status & ~fifo_pop & ~hold_push & rx_on) |=>
		$stable(rd_ptr_reg) && $stable(count_reg)) else $error("status write moved FIFO");
	rx_done_hold_a: assert property (rx_done |=> hold_valid_reg &&
		hold_reg.fe == ~$past(rxd_f_reg)) else $error("frame error not stored");

	frame_sent_c: cover property (tx_end ##1 txc_reg);
	frame_stored_c: cover property (hold_push ##[1:4] rx_complete);
	overrun_c: cover property (rx_ovr);
	parity_err_c: cover property (rx_done & rx_pe);

endmodule // ufr_uart

// ### rtl/ufr_pkg.sv
package ufr_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] UFR_OFF_DATA   = 5'h00;
	localparam logic [4:0] UFR_OFF_STATUS = 5'h04;
	localparam logic [4:0] UFR_OFF_CTRL   = 5'h08;
	localparam logic [4:0] UFR_OFF_FORMAT = 5'h0C;
	localparam logic [4:0] UFR_OFF_BAUD   = 5'h10;

	// Status register bit positions.
	localparam int UFR_ST_RXC  = 7;
	localparam int UFR_ST_TXC  = 6;
	localparam int UFR_ST_UDRE = 5;
	localparam int UFR_ST_FE   = 4;
	localparam int UFR_ST_DOR  = 3;
	localparam int UFR_ST_UPE  = 2;

	// Control register bit positions.
	localparam int UFR_CT_RXCIE = 7;
	localparam int UFR_CT_TXCIE = 6;
	localparam int UFR_CT_UDRIE = 5;
	localparam int UFR_CT_RXEN  = 4;
	localparam int UFR_CT_TRANSMITTER_ENABLE  = 3;
	localparam int UFR_CT_SIZE2 = 2;
	localparam int UFR_CT_RXB8  = 1;
	localparam int UFR_CT_TX_NINTH_BIT  = 0;

	// Format register bit positions.
	localparam int UFR_FM_SYNC    = 6;
	localparam int UFR_FM_PAR_EN  = 5;
	localparam int UFR_FM_PAR_ODD = 4;
	localparam int UFR_FM_STOP2   = 3;
	localparam int UFR_FM_SIZE_LO = 1;

	// Reset values.
	localparam logic [7:0]  UFR_CTRL_RST   = 8'h00;
	localparam logic [7:0]  UFR_FORMAT_RST = 8'h06;
	localparam logic [15:0] UFR_BAUD_RST   = 16'h0A2B;

	localparam logic [2:0] UFR_SIZE_NINE = 3'h7;

	typedef struct packed {
		logic       dor;
		logic       fe;
		logic       pe;
		logic [8:0] data;
	} ufr_rx_entry_t;

	typedef struct packed {
		logic       sync_mode;
		logic       parity_enable_bit;
		logic       parity_type_bit;
		logic       stop_bits_select;
		logic [2:0] char_size_field;
	} ufr_frame_cfg_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} ufr_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ufr_rx_state_t;

endpackage

// ### testbench/ufr_remote.sv
`timescale 1ns/1ps
module ufr_remote #(
	parameter int BIT_CLKS = 4
)(
	input  wire logic mclk,
	input  wire logic serial_out_pin,
	input  wire logic serial_out_pin_oe,
	output logic      serial_in_pin,
	output logic      sync_clk
);
	logic [11:0] cap_bits = 12'h000;
	int          cap_len = 11;
	int          cap_count = 0;

	initial serial_in_pin = 1'b1;
	initial sync_clk = 1'b0;

	// Bits go out least significant first; the line idles high between frames.
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			serial_in_pin <= bits[i];
			repeat (BIT_CLKS) @(posedge mclk);
		end
		serial_in_pin <= 1'b1;
		@(posedge mclk);
	endtask

	// Sync mode: data is set up half a clock period before each rising clock edge.
	task automatic send_sync(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			serial_in_pin <= bits[i];
			repeat (BIT_CLKS) @(posedge mclk);
			sync_clk <= 1'b1;
			repeat (BIT_CLKS) @(posedge mclk);
			sync_clk <= 1'b0;
		end
		serial_in_pin <= 1'b1;
		@(posedge mclk);
	endtask

	// Samples mid-bit so the registered output edges never race the sample.
	always
	begin
		@(negedge serial_out_pin iff serial_out_pin_oe);
		repeat (BIT_CLKS / 2) @(posedge mclk);
		for (int i = 0; i < cap_len; i++)
		begin
			cap_bits[i] = serial_out_pin;
			if (i < cap_len - 1)
				repeat (BIT_CLKS) @(posedge mclk);
		end
		cap_count++;
	end
endmodule // ufr_remote

// ### testbench/uart_flags_rx_tx_parity_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin n_fail++; \
	$display("unexpected %s expected %h seen %h", nm, ex, sn); end end
module uart_flags_rx_tx_parity_bench;
	import ufr_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        global_irq_enable = 1'b1;
	logic        tx_complete_irq_ack = 1'b0;
	logic        irq_tx_empty;
	logic        irq_tx_complete;
	logic        irq_rx_complete;
	logic        serial_in_pin;
	logic        serial_out_pin;
	logic        serial_out_pin_oe;
	logic        serial_in_claim;
	logic        sync_clk;
	int          n_fail = 0;
	int          checks_done = 0;
	int          cycles = 0;

	ufr_uart u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.global_irq_enable(global_irq_enable), .tx_complete_irq_ack(tx_complete_irq_ack),
		.irq_tx_empty(irq_tx_empty), .irq_tx_complete(irq_tx_complete),
		.irq_rx_complete(irq_rx_complete), .serial_in_pin(serial_in_pin),
		.sync_transfer_clock_pin(sync_clk), .serial_out_pin(serial_out_pin),
		.serial_out_pin_oe(serial_out_pin_oe), .serial_in_claim(serial_in_claim));
	ufr_remote #(.BIT_CLKS(4)) u_rem (.mclk(mclk), .serial_out_pin(serial_out_pin),
		.serial_out_pin_oe(serial_out_pin_oe), .serial_in_pin(serial_in_pin),
		.sync_clk(sync_clk));

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			finish_test;
		end
	end

	task automatic finish_test;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		// Waitrequest and read data are looked at between edges, where they have settled.
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			n_fail++;
		q = avs_readdata;
		@(posedge mclk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask

	function automatic logic [10:0] frame(input logic [7:0] d, input logic odd);
		return {1'b1, ^d ^ odd, d, 1'b0};
	endfunction

	task automatic wait_cap(input int k);
		for (int i = 0; i < 200 && u_rem.cap_count < k; i++)
			@(posedge mclk);
	endtask

	task automatic t_reset;
		logic [31:0] q;
		bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("status rst", 8'h20, q[7:0])
		bus(0, UFR_OFF_CTRL, 8'h00, q);
		`CHK("ctrl rst", UFR_CTRL_RST, q[7:0])
		bus(0, UFR_OFF_FORMAT, 8'h00, q);
		`CHK("format rst", UFR_FORMAT_RST, q[7:0])
		bus(1, 5'h14, 8'h5A, q);
		bus(0, 5'h14, 8'h00, q);
		`CHK("unmapped", 32'h0, q)
		bus(1, UFR_OFF_BAUD, 8'h03, q);
		bus(0, UFR_OFF_BAUD, 8'h00, q);
		`CHK("baud", 16'h0003, q[15:0])
	endtask

	// Two back-to-back characters, then the transmitter is disabled while both are pending.
	task automatic t_tx(input logic [7:0] fmt, input logic [7:0] d0, input logic [7:0] d1);
		logic [31:0] q;
		int          k;
		k = u_rem.cap_count;
		bus(1, UFR_OFF_FORMAT, fmt, q);
		bus(1, UFR_OFF_CTRL, 8'h68, q);
		bus(1, UFR_OFF_DATA, d0, q);
		bus(1, UFR_OFF_DATA, d1, q);
		bus(1, UFR_OFF_CTRL, 8'h60, q);
		bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("empty pending", 1'b0, q[UFR_ST_UDRE])
		`CHK("irq empty low", 1'b0, irq_tx_empty)
		`CHK("oe held", 1'b1, serial_out_pin_oe)
		wait_cap(k + 1);
		`CHK("frame 0", frame(d0, fmt[4]), u_rem.cap_bits[10:0])
		wait_cap(k + 2);
		`CHK("frame 1", frame(d1, fmt[4]), u_rem.cap_bits[10:0])
		for (int i = 0; i < 40 && q[UFR_ST_TXC] !== 1'b1; i++)
			bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("tx complete", 8'h60, q[7:0])
		`CHK("irq complete", 1'b1, irq_tx_complete)
		`CHK("irq empty", 1'b1, irq_tx_empty)
		`CHK("oe released", 1'b0, serial_out_pin_oe)
		if (fmt[UFR_FM_PAR_ODD])
		begin
			tx_complete_irq_ack <= 1'b1;
			@(posedge mclk);
			tx_complete_irq_ack <= 1'b0;
			@(posedge mclk);
		end
		else
			bus(1, UFR_OFF_STATUS, 8'h40, q);
		bus(1, UFR_OFF_CTRL, 8'h00, q);
		bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("tx complete clr", 1'b0, q[UFR_ST_TXC])
		`CHK("irq complete clr", 1'b0, irq_tx_complete)
	endtask

	task automatic rd_check(input logic [7:0] st, input logic [7:0] d);
		logic [31:0] q;
		bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("rx status", st, q[7:0])
		bus(0, UFR_OFF_DATA, 8'h00, q);
		`CHK("rx data", d, q[7:0])
	endtask

	task automatic t_rx;
		logic [31:0] q;
		bus(1, UFR_OFF_FORMAT, 8'h26, q);
		bus(1, UFR_OFF_CTRL, 8'h90, q);
		u_rem.send({1'b0, frame(8'h5A, 1'b0)}, 11);
		u_rem.send({1'b0, frame(8'h33, 1'b0) ^ 11'h600}, 11);
		repeat (30) @(posedge mclk);
		bus(1, UFR_OFF_STATUS, 8'h40, q);
		`CHK("claim", 1'b1, serial_in_claim)
		`CHK("irq rx", 1'b1, irq_rx_complete)
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge mclk);
		`CHK("irq rx gated", 1'b0, irq_rx_complete)
		global_irq_enable <= 1'b1;
		rd_check(8'hA0, 8'h5A);
		rd_check(8'hB4, 8'h33);
		bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("rx empty", 8'h20, q[7:0])
		for (int i = 0; i < 4; i++)
			u_rem.send({1'b0, frame(8'h11 << i, 1'b0)}, 11);
		repeat (30) @(posedge mclk);
		rd_check(8'hA0, 8'h11);
		rd_check(8'hA0, 8'h22);
		rd_check(8'hA8, 8'h88);
		u_rem.send({1'b0, frame(8'h5A, 1'b0)}, 11);
		repeat (30) @(posedge mclk);
		bus(1, UFR_OFF_CTRL, 8'h00, q);
		bus(0, UFR_OFF_STATUS, 8'h00, q);
		`CHK("flushed", 8'h20, q[7:0])
		`CHK("claim off", 1'b0, serial_in_claim)
	endtask

	// Sync mode: the receiver samples on the rising edge of the external transfer clock.
	task automatic t_sync;
		logic [31:0] q;
		bus(1, UFR_OFF_FORMAT, 8'h46, q);
		bus(1, UFR_OFF_CTRL, 8'h10, q);
		u_rem.send_sync({1'b1, 8'hC3, 1'b0}, 10);
		repeat (10) @(posedge mclk);
		rd_check(8'hA0, 8'hC3);
		u_rem.send_sync({1'b0, 8'h3C, 1'b0}, 10);
		repeat (10) @(posedge mclk);
		rd_check(8'hB0, 8'h3C);
		bus(1, UFR_OFF_CTRL, 8'h00, q);
	endtask

	task automatic t_size;
		logic [31:0] q;
		int          k;
		bus(1, UFR_OFF_FORMAT, 8'h00, q);
		bus(1, UFR_OFF_CTRL, 8'h10, q);
		u_rem.send({5'h00, 1'b1, 5'h15, 1'b0}, 7);
		repeat (30) @(posedge mclk);
		rd_check(8'hA0, 8'h15);
		bus(1, UFR_OFF_FORMAT, 8'h06, q);
		bus(1, UFR_OFF_CTRL, 8'h14, q);
		u_rem.send({1'b1, 9'h1A5, 1'b0}, 11);
		repeat (30) @(posedge mclk);
		bus(0, UFR_OFF_CTRL, 8'h00, q);
		`CHK("ninth bit", 1'b1, q[UFR_CT_RXB8])
		rd_check(8'hA0, 8'hA5);
		bus(1, UFR_OFF_CTRL, 8'h0D, q);
		k = u_rem.cap_count;
		bus(1, UFR_OFF_DATA, 8'h3C, q);
		wait_cap(k + 1);
		`CHK("ninth tx", {1'b1, 9'h13C, 1'b0}, u_rem.cap_bits[10:0])
		bus(1, UFR_OFF_CTRL, 8'h00, q);
	endtask

	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reset;
		t_tx(8'h26, 8'hA5, 8'h07);
		t_tx(8'h36, 8'h07, 8'hA5);
		t_rx;
		t_sync;
		t_size;
		finish_test;
	end
endmodule // uart_flags_rx_tx_parity_bench
